// [psp_cmd_handler.sv]
// programming-mode command decoder and responder
//
// Overview of operation
// - short code 100 starts nvm programming, answers ok with 0x2AA; outside programming mode it gets no response
// - short codes 101, 110 and correctly framed extra-long frames get no response
// - short code 111 enters programming mode, answers ok 0x0CA; a crc error gets no response
// - long read, address 001 code 010, answers ok with two array bytes
// - reading the last array byte returns zero in the second data word
// - long write code 011 stores nibble, answers updated byte then nibble address
// - response code 0x1E1 ok, 0x1E2 error; long error ends with 0x000
// - error number sits in low four bits of first data word, rest zero
// - produced error numbers: framing 0001, crc 0010, unsupported address 0101
// - write to a locked destination is rejected with error 0110
// - unsupported sensor address is ignored silently
// - fixed internal delay after nvm command before the otp write begins
// - sync pulses are ignored while the otp write runs
// - on completion shadow reloads from otp and load-done flag sets
// - 3-bit crc x^3+x+1, seed 111, over payload lsb first, no start/sync
// - master sends two or three sync pulses; one response word per pulse
// - missing sync bit flags the frame; after frame end the next sync answers short framing error
`timescale 1ns/1ps
module psp_cmd_handler
  import psp_pkg::*;
#(
  parameter int ARRAY_BYTES = 24,
  parameter int PROG_DELAY_NS = 100000,
  parameter int PROG_WRITE_NS = 1000000
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic cmd_bit_vld_in,
  input wire logic cmd_bit_in,
  input wire logic cmd_end_in,
  input wire logic sync_pulse_in,
  output logic resp_vld_out,
  output logic [9:0] resp_word_out,
  output logic prog_mode_out,
  output logic otp_busy_out,
  output logic otp_load_done_out
);

  localparam int PROG_DELAY_CYC = (PROG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_WRITE_CYC = (PROG_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  psp_state_t state_ff;
  logic [5:0] raw_cnt_ff;
  logic [1:0] phase_ff;
  logic [5:0] pay_cnt_ff;
  logic [2:0] start_ff;
  logic [2:0] dly_ff;
  logic frm_err_ff;
  logic [PAYLOAD_W-1:0] pay_ff;
  logic [2:0] crc_calc;
  logic rx_bit;
  logic pay_bit;
  logic [9:0] word_ff [3];
  logic [1:0] last_idx_ff;
  logic [1:0] idx_ff;
  logic armed_ff;
  logic [31:0] cnt_ff;
  logic burn;
  logic reload;
  logic [7:0] shadow_ff [ARRAY_BYTES];
  logic [7:0] otp_ff [ARRAY_BYTES];

  ////////////////////////////////////////////////////////////////////////////
  // frame reception: start bits, stuffed sync bits, payload

  // commands are taken only while no programming sequence is running
  assign rx_bit = cmd_bit_vld_in && !cmd_end_in && (state_ff == ST_IDLE);
  assign pay_bit = rx_bit && (raw_cnt_ff >= 6'(START_BITS)) && (phase_ff != 2'h0);

  always_ff @(posedge mclk_in) begin
    if (srst_in || cmd_end_in) begin
      raw_cnt_ff <= 6'h00;
      phase_ff <= 2'h0;
      pay_cnt_ff <= 6'h00;
      start_ff <= 3'h0;
      frm_err_ff <= 1'b0;
    end else if (rx_bit) begin
      if (raw_cnt_ff != 6'h3F) begin
        raw_cnt_ff <= raw_cnt_ff + 6'h01;
      end
      if (raw_cnt_ff < 6'(START_BITS)) begin
        start_ff <= {start_ff[1:0], cmd_bit_in};
      end else begin
        phase_ff <= phase_ff + 2'h1;
        if (phase_ff == 2'h0 && !cmd_bit_in) begin
          frm_err_ff <= 1'b1;
        end
        if (phase_ff != 2'h0 && pay_cnt_ff != 6'h3F) begin
          pay_cnt_ff <= pay_cnt_ff + 6'h01;
        end
      end
    end
  end

  // payload store and a 3-bit delay so the trailing crc is never fed in
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pay_ff <= '0;
      dly_ff <= 3'h0;
    end else if (pay_bit) begin
      if (pay_cnt_ff < 6'(PAYLOAD_W)) begin
        pay_ff[pay_cnt_ff[3:0]] <= cmd_bit_in;
      end
      dly_ff <= {dly_ff[1:0], cmd_bit_in};
    end
  end

  psp_crc3 u_crc (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .init_in(rx_bit && raw_cnt_ff == 6'h00),
    .en_in(pay_bit && pay_cnt_ff >= 6'h03),
    .bit_in(dly_ff[2]),
    .crc_out(crc_calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decode at end of frame

  logic [2:0] sa;
  logic [2:0] fc;
  logic [5:0] ra;
  logic [4:0] bidx;
  logic [3:0] wnib;
  logic [7:0] new_byte;
  logic is_short;
  logic is_long;
  logic dec_arm;
  logic [1:0] dec_last;
  logic [9:0] dec_w0;
  logic [9:0] dec_w1;
  logic [9:0] dec_w2;
  logic do_entry;
  logic do_prog;
  logic do_write;

  assign sa = pay_ff[SA_POS+:3];
  assign fc = pay_ff[FC_POS+:3];
  assign ra = pay_ff[RA_POS+:6];
  assign wnib = pay_ff[WD_POS+:4];
  assign bidx = ra[5:1];
  assign is_short = pay_cnt_ff == SHORT_BITS;
  assign is_long = pay_cnt_ff == LONG_BITS;

  always_comb begin
    dec_arm = 1'b0;
    dec_last = 2'h1;
    dec_w0 = RC_OK;
    dec_w1 = RD_ZERO;
    dec_w2 = RD_ZERO;
    do_entry = 1'b0;
    do_prog = 1'b0;
    do_write = 1'b0;
    new_byte = BYTE_RESET;
    if (!cmd_end_in || raw_cnt_ff == 6'h00) begin
      dec_arm = 1'b0;
    end else if (frm_err_ff || start_ff != START_PATTERN || pay_cnt_ff < SHORT_BITS
                 || (!is_short && pay_cnt_ff < LONG_BITS)
                 || (!is_short && !is_long && pay_cnt_ff > LONG_BITS && 1'b0)) begin
      dec_arm = 1'b1;
      dec_w0 = RC_ERR;
      dec_w1 = {6'h00, ERROR_NUMBER_FRAMING};
    end else if (!is_short && !is_long) begin
      dec_arm = 1'b0;
    end else if (crc_calc != dly_ff) begin
      if (!(is_short && fc == FC_ENTER)) begin
        dec_arm = 1'b1;
        dec_w0 = RC_ERR;
        dec_w1 = {6'h00, ERROR_NUMBER_CRC};
        dec_last = is_long ? 2'h2 : 2'h1;
      end
    end else if (sa != SENSOR_ADDR) begin
      dec_arm = 1'b0;
    end else if (is_short) begin
      case (fc)
        FC_ENTER: begin
          dec_arm = 1'b1;
          dec_w1 = RD_ENTER_OK;
          do_entry = 1'b1;
        end
        FC_NVM: begin
          dec_arm = prog_mode_out;
          dec_w1 = RD_NVM_OK;
          do_prog = prog_mode_out;
        end
        default: begin
          dec_arm = 1'b0;
        end
      endcase
    end else if (prog_mode_out && (fc == FC_READ || fc == FC_WRITE)) begin
      dec_arm = 1'b1;
      dec_last = 2'h2;
      if (32'(bidx) >= ARRAY_BYTES) begin
        dec_w0 = RC_ERR;
        dec_w1 = {6'h00, ERROR_NUMBER_RANGE};
      end else if (fc == FC_WRITE && otp_ff[LOCK_BYTE][LOCK_BIT]) begin
        dec_w0 = RC_ERR;
        dec_w1 = {6'h00, ERROR_NUMBER_WPROT};
      end else if (fc == FC_READ) begin
        dec_w1 = {2'h0, shadow_ff[bidx]};
        if (32'(bidx) == ARRAY_BYTES - 1) begin
          dec_w2 = RD_ZERO;
        end else begin
          dec_w2 = {2'h0, shadow_ff[bidx + 5'h01]};
        end
      end else begin
        new_byte = ra[0] ? {wnib, shadow_ff[bidx][3:0]} : {shadow_ff[bidx][7:4], wnib};
        dec_w1 = {2'h0, new_byte};
        dec_w2 = {4'h0, ra};
        do_write = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response words, one per accepted sync pulse

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      armed_ff <= 1'b0;
      idx_ff <= 2'h0;
      last_idx_ff <= 2'h1;
      resp_vld_out <= 1'b0;
      resp_word_out <= RD_ZERO;
      for (int i = 0; i < 3; i++) begin
        word_ff[i] <= RD_ZERO;
      end
    end else begin
      resp_vld_out <= 1'b0;
      if (dec_arm) begin
        armed_ff <= 1'b1;
        idx_ff <= 2'h0;
        last_idx_ff <= dec_last;
        word_ff[0] <= dec_w0;
        word_ff[1] <= dec_w1;
        word_ff[2] <= dec_w2;
      end else if (rx_bit && raw_cnt_ff == 6'h00) begin
        armed_ff <= 1'b0;
      end else if (sync_pulse_in && armed_ff && !otp_busy_out) begin
        resp_vld_out <= 1'b1;
        resp_word_out <= word_ff[idx_ff];
        idx_ff <= idx_ff + 2'h1;
        if (idx_ff == last_idx_ff) begin
          armed_ff <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming mode and otp programming sequence

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      prog_mode_out <= 1'b0;
    end else if (do_entry) begin
      prog_mode_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (do_prog) begin
            state_ff <= ST_PDLY;
            cnt_ff <= 32'(PROG_DELAY_CYC - 1);
          end
        end
        ST_PDLY: begin
          if (cnt_ff == 32'h0000_0000) begin
            state_ff <= ST_PWR;
            cnt_ff <= 32'(PROG_WRITE_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 32'h0000_0001;
          end
        end
        ST_PWR: begin
          if (cnt_ff == 32'h0000_0000) begin
            state_ff <= ST_LOAD;
          end else begin
            cnt_ff <= cnt_ff - 32'h0000_0001;
          end
        end
        ST_LOAD: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign burn = (state_ff == ST_PWR) && (cnt_ff == 32'h0000_0000);
  assign reload = state_ff == ST_LOAD;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      otp_busy_out <= 1'b0;
      otp_load_done_out <= 1'b0;
    end else begin
      otp_busy_out <= (state_ff == ST_PDLY && cnt_ff == 32'h0000_0000)
                      || (state_ff == ST_PWR && !burn);
      if (reload) begin
        otp_load_done_out <= 1'b1;
      end else if (do_prog) begin
        otp_load_done_out <= 1'b0;
      end
    end
  end

  // per-byte shadow register and its programmed copy
  for (genvar g = 0; g < ARRAY_BYTES; g++) begin : g_byte
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        shadow_ff[g] <= BYTE_RESET;
        otp_ff[g] <= BYTE_RESET;
      end else begin
        if (burn) begin
          otp_ff[g] <= shadow_ff[g];
        end
        if (reload) begin
          shadow_ff[g] <= otp_ff[g];
        end else if (do_write && 32'(bidx) == g) begin
          shadow_ff[g] <= new_byte;
        end
      end
    end
  end

endmodule

// [psp_pkg.sv]
// constants and types shared by the programming-mode command handler
package psp_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // command frame layout, counted in payload bits (start and stuffed bits removed)
  localparam int START_BITS = 3;
  localparam logic [2:0] START_PATTERN = 3'h2;
  localparam logic [5:0] SHORT_BITS = 6'h09;
  localparam logic [5:0] LONG_BITS = 6'h13;
  localparam int SA_POS = 0;
  localparam int FC_POS = 3;
  localparam int RA_POS = 6;
  localparam int WD_POS = 12;
  localparam int PAYLOAD_W = 16;
  localparam logic [2:0] SENSOR_ADDR = 3'h1;
  // function codes
  localparam logic [2:0] FC_NVM = 3'h4;
  localparam logic [2:0] FC_ENTER = 3'h7;
  localparam logic [2:0] FC_READ = 3'h2;
  localparam logic [2:0] FC_WRITE = 3'h3;
  // response words
  localparam logic [9:0] RC_OK = 10'h1E1;
  localparam logic [9:0] RC_ERR = 10'h1E2;
  localparam logic [9:0] RD_NVM_OK = 10'h2AA;
  localparam logic [9:0] RD_ENTER_OK = 10'h0CA;
  localparam logic [9:0] RD_ZERO = 10'h000;
  localparam logic [3:0] ERROR_NUMBER_FRAMING = 4'h1;
  localparam logic [3:0] ERROR_NUMBER_CRC = 4'h2;
  localparam logic [3:0] ERROR_NUMBER_RANGE = 4'h5;
  localparam logic [3:0] ERROR_NUMBER_WPROT = 4'h6;
  // command crc
  localparam logic [2:0] CRC_SEED = 3'h7;
  localparam logic [2:0] CRC_POLY = 3'h3;
  // write-lock bit location in the programmed array
  localparam logic [4:0] LOCK_BYTE = 5'h00;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PDLY = 4'h2,
    ST_PWR = 4'h4,
    ST_LOAD = 4'h8
  } psp_state_t;
endpackage

// [psp_crc3.sv]
// serial 3-bit command crc, remainder after three augmenting zeros
`timescale 1ns/1ps
module psp_crc3
  import psp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic init_in,
  input wire logic en_in,
  input wire logic bit_in,
  output logic [2:0] crc_out
);

  logic [2:0] rem_ff;

  function automatic logic [2:0] crc_step(input logic [2:0] r, input logic b);
    crc_step = {r[1:0], b} ^ (r[2] ? CRC_POLY : 3'h0);
  endfunction

  always_ff @(posedge mclk_in) begin
    if (srst_in || init_in) begin
      rem_ff <= CRC_SEED;
    end else if (en_in) begin
      rem_ff <= crc_step(rem_ff, bit_in);
    end
  end

  assign crc_out = crc_step(crc_step(crc_step(rem_ff, 1'b0), 1'b0), 1'b0);

endmodule

// [psp_cmd_handler_properties.sv]
// port assertions for the command handler
`timescale 1ns/1ps
module psp_cmd_handler_chk
  import psp_pkg::*;
#(
  parameter int PROG_DELAY_NS = 100000,
  parameter int PROG_WRITE_NS = 1000000
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic cmd_bit_vld_in,
  input wire logic cmd_bit_in,
  input wire logic cmd_end_in,
  input wire logic sync_pulse_in,
  input wire logic resp_vld_out,
  input wire logic [9:0] resp_word_out,
  input wire logic prog_mode_out,
  input wire logic otp_busy_out,
  input wire logic otp_load_done_out
);
  localparam int DLY = (PROG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR = (PROG_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  logic err_ff;
  int end_cnt_ff;
  int busy_cnt_ff;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // remembers that the last word sent was an error code
  always_ff @(posedge mclk_in) begin
    if (srst_in || resp_vld_out || cmd_bit_vld_in) begin
      err_ff <= !srst_in && resp_vld_out && resp_word_out == RC_ERR;
    end
  end
  always_ff @(posedge mclk_in) begin
    end_cnt_ff <= cmd_end_in ? 0 : end_cnt_ff + 1;
  end
  always_ff @(posedge mclk_in) begin
    busy_cnt_ff <= otp_busy_out ? busy_cnt_ff + 1 : 0;
  end
  sequence s_taken_sync;
    $past(sync_pulse_in) && !$past(otp_busy_out);
  endsequence
  sequence s_busy_end;
    $fell(otp_busy_out);
  endsequence
  chk_resp_latency: assert property (resp_vld_out |-> s_taken_sync)
    else $error("response word without a taken sync pulse");
  chk_busy_quiet: assert property (sync_pulse_in && otp_busy_out |=> !resp_vld_out)
    else $error("answer given during otp write");
  chk_word_hold: assert property (!resp_vld_out && !$past(srst_in) |-> $stable(resp_word_out))
    else $error("response word changed without valid");
  chk_err_data: assert property (resp_vld_out && err_ff |-> resp_word_out[9:4] == 6'h00)
    else $error("error data word has high bits set");
  chk_nvm_delay: assert property ($rose(otp_busy_out) |-> end_cnt_ff >= DLY - 1)
    else $error("otp write began before the internal delay");
  chk_write_len: assert property (s_busy_end |-> busy_cnt_ff >= WR - 1)
    else $error("otp write ended too early");
  chk_load_done: assert property (s_busy_end |-> ##[0:4] otp_load_done_out)
    else $error("load-done flag missing after otp write");
  chk_mode_hold: assert property (prog_mode_out |=> prog_mode_out)
    else $error("programming mode dropped");
  chk_mode_rise: assert property ($rose(prog_mode_out) |-> $past(cmd_end_in))
    else $error("programming mode entered without a frame end");
endmodule
bind psp_cmd_handler psp_cmd_handler_chk #(
  .PROG_DELAY_NS(PROG_DELAY_NS),
  .PROG_WRITE_NS(PROG_WRITE_NS)
) u_chk (
  .mclk_in(mclk_in),
  .srst_in(srst_in),
  .cmd_bit_vld_in(cmd_bit_vld_in),
  .cmd_bit_in(cmd_bit_in),
  .cmd_end_in(cmd_end_in),
  .sync_pulse_in(sync_pulse_in),
  .resp_vld_out(resp_vld_out),
  .resp_word_out(resp_word_out),
  .prog_mode_out(prog_mode_out),
  .otp_busy_out(otp_busy_out),
  .otp_load_done_out(otp_load_done_out)
);

// [psp_ecu_model.sv]
// ecu master model: stuffed command frames and response sync pulses
`timescale 1ns/1ps
module psp_ecu_model
  import psp_pkg::*;
(
  input wire logic mclk_in,
  output logic cmd_bit_vld_out,
  output logic cmd_bit_out,
  output logic cmd_end_out,
  output logic sync_pulse_out
);
  initial begin
    cmd_bit_vld_out = 1'b0;
    cmd_bit_out = 1'b1;
    cmd_end_out = 1'b0;
    sync_pulse_out = 1'b0;
  end
  function automatic logic [2:0] crc3(input logic [19:0] p, input int n);
    logic [2:0] r;
    r = CRC_SEED;
    for (int i = 0; i < n + 3; i++) begin
      r = {r[1:0], (i < n) ? p[i] : 1'b0} ^ (r[2] ? CRC_POLY : 3'h0);
    end
    return r;
  endfunction
  // bad_crc flips the crc lsb, bad_sy clears the first stuff bit
  task automatic send(input logic [19:0] p, input int n, input logic bad_crc,
                      input logic bad_sy);
    logic [22:0] pl;
    logic [2:0] c;
    int k;
    c = crc3(p, n) ^ {2'h0, bad_crc};
    pl = {3'h0, p};
    pl[n] = c[2];
    pl[n+1] = c[1];
    pl[n+2] = c[0];
    k = 0;
    for (int r = 0; k < n + 3; r++) begin
      @(negedge mclk_in);
      cmd_bit_vld_out = 1'b1;
      if (r < 3) begin
        cmd_bit_out = (r == 1);
      end else if (r % 4 == 3) begin
        cmd_bit_out = !(bad_sy && r == 3);
      end else begin
        cmd_bit_out = pl[k];
        k++;
      end
    end
    @(negedge mclk_in);
    cmd_bit_vld_out = 1'b0;
    cmd_bit_out = !cmd_bit_out;
    @(negedge mclk_in);
    cmd_end_out = 1'b1;
    @(negedge mclk_in);
    cmd_end_out = 1'b0;
  endtask
  task automatic sync();
    @(negedge mclk_in);
    sync_pulse_out = 1'b1;
    @(negedge mclk_in);
    sync_pulse_out = 1'b0;
  endtask
endmodule

// [psp_cmd_handler_bench.sv]
// self-checking bench for the programming-mode command handler
`timescale 1ns/1ps
module psp_cmd_handler_bench import psp_pkg::*;;
  logic mclk_in;
  logic srst_in;
  logic cmd_bit_vld_in;
  logic cmd_bit_in;
  logic cmd_end_in;
  logic sync_pulse_in;
  logic resp_vld_out;
  logic [9:0] resp_word_out;
  logic prog_mode_out;
  logic otp_busy_out;
  logic otp_load_done_out;
  int err_count;
  int tests_run;
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  psp_cmd_handler #(.ARRAY_BYTES(24), .PROG_DELAY_NS(40), .PROG_WRITE_NS(80)) dut (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .cmd_bit_vld_in(cmd_bit_vld_in),
    .cmd_bit_in(cmd_bit_in),
    .cmd_end_in(cmd_end_in),
    .sync_pulse_in(sync_pulse_in),
    .resp_vld_out(resp_vld_out),
    .resp_word_out(resp_word_out),
    .prog_mode_out(prog_mode_out),
    .otp_busy_out(otp_busy_out),
    .otp_load_done_out(otp_load_done_out)
  );
  psp_ecu_model u_ecu (
    .mclk_in(mclk_in),
    .cmd_bit_vld_out(cmd_bit_vld_in),
    .cmd_bit_out(cmd_bit_in),
    .cmd_end_out(cmd_end_in),
    .sync_pulse_out(sync_pulse_in)
  );
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // three sync pulses: n words expected, then silence
  task automatic rsp(input logic [9:0] w0, w1, w2, input int n);
    logic [9:0] w [3];
    w = '{w0, w1, w2};
    for (int i = 0; i < 3; i++) begin
      u_ecu.sync();
      chk({9'h0, resp_vld_out}, {9'h0, 1'(i < n)});
      if (i < n) begin
        chk(resp_word_out, w[i]);
      end
    end
  endtask
  task automatic cmd(input logic [2:0] fc, input logic [5:0] ra, input logic [3:0] d,
                     input int n, input logic [1:0] bad);
    u_ecu.send({4'h0, d, ra, fc, SENSOR_ADDR}, n, bad[0], bad[1]);
  endtask
  task automatic t_entry();
    chk(resp_word_out, RD_ZERO);
    chk({9'h0, prog_mode_out}, 10'h000);
    cmd(FC_ENTER, 6'h00, 4'h0, 6, 2'h0);
    rsp(RC_OK, RD_ENTER_OK, RD_ZERO, 2);
    chk({9'h0, prog_mode_out}, 10'h001);
    $display("entry test done");
  endtask
  task automatic t_rw();
    cmd(FC_WRITE, 6'h04, 4'hA, 16, 2'h0);
    rsp(RC_OK, 10'h00A, 10'h004, 3);
    cmd(FC_WRITE, 6'h05, 4'h5, 16, 2'h0);
    rsp(RC_OK, 10'h05A, 10'h005, 3);
    cmd(FC_READ, 6'h02, 4'h0, 16, 2'h0);
    rsp(RC_OK, 10'h000, 10'h05A, 3);
    cmd(FC_WRITE, 6'h2F, 4'hF, 16, 2'h0);
    rsp(RC_OK, 10'h0F0, 10'h02F, 3);
    cmd(FC_READ, 6'h2E, 4'h0, 16, 2'h0);
    rsp(RC_OK, 10'h0F0, RD_ZERO, 3);
    cmd(FC_WRITE, 6'h01, 4'h8, 16, 2'h0);
    rsp(RC_OK, 10'h080, 10'h001, 3);
    $display("read write test done");
  endtask
  task automatic t_err();
    cmd(FC_READ, 6'h04, 4'h0, 16, 2'h1);
    rsp(RC_ERR, 10'h002, RD_ZERO, 3);
    cmd(FC_READ, 6'h30, 4'h0, 16, 2'h0);
    rsp(RC_ERR, 10'h005, RD_ZERO, 3);
    cmd(FC_ENTER, 6'h00, 4'h0, 6, 2'h2);
    rsp(RC_ERR, 10'h001, RD_ZERO, 2);
    cmd(FC_ENTER, 6'h00, 4'h0, 6, 2'h1);
    rsp(RD_ZERO, RD_ZERO, RD_ZERO, 0);
    $display("error test done");
  endtask
  task automatic t_silent();
    logic [2:0] fcs [4];
    fcs = '{3'h5, 3'h6, 3'h0, 3'h1};
    for (int i = 0; i < 4; i++) begin
      cmd(fcs[i], 6'h04, 4'h0, (i < 2) ? 6 : 20, 2'h0);
      rsp(RD_ZERO, RD_ZERO, RD_ZERO, 0);
    end
    u_ecu.send({4'h0, 4'h0, 6'h04, FC_READ, 3'h2}, 16, 1'b0, 1'b0);
    rsp(RD_ZERO, RD_ZERO, RD_ZERO, 0);
    $display("silent test done");
  endtask
  task automatic t_nvm();
    int k;
    cmd(FC_NVM, 6'h00, 4'h0, 6, 2'h0);
    // only the code word now; the data word stays armed across the otp write
    u_ecu.sync();
    chk({9'h0, resp_vld_out}, 10'h001);
    chk(resp_word_out, RC_OK);
    for (k = 0; otp_busy_out !== 1'b1 && k < 100; k++) begin
      @(negedge mclk_in);
    end
    chk({9'h0, otp_busy_out}, 10'h001);
    u_ecu.sync();
    chk({9'h0, resp_vld_out}, 10'h000);
    for (k = 0; otp_load_done_out !== 1'b1 && k < 200; k++) begin
      @(negedge mclk_in);
    end
    chk({9'h0, otp_load_done_out}, 10'h001);
    u_ecu.sync();
    chk({9'h0, resp_vld_out}, 10'h001);
    chk(resp_word_out, RD_NVM_OK);
    cmd(FC_READ, 6'h02, 4'h0, 16, 2'h0);
    rsp(RC_OK, 10'h000, 10'h05A, 3);
    cmd(FC_WRITE, 6'h00, 4'h3, 16, 2'h0);
    rsp(RC_ERR, 10'h006, RD_ZERO, 3);
    $display("nvm test done");
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_in);
    err_count++;
    finish_test();
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    srst_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    srst_in = 1'b0;
    t_entry();
    t_rw();
    t_err();
    t_silent();
    t_nvm();
    finish_test();
  end
endmodule
